/* shared/fsac_defines.svh */
`ifndef FSAC_DEFINES_SVH
`define FSAC_DEFINES_SVH

// ==================================================
// flash geometry (word addresses)
`define FSAC_ADDR_W        16
`define FSAC_HALT_START    16'hF000
`define FSAC_BOOT_WORDS_3  16'h0200
`define FSAC_BOOT_WORDS_2  16'h0400
`define FSAC_BOOT_WORDS_1  16'h0800
`define FSAC_BOOT_WORDS_0  16'h1000

// ==================================================
// apb register offsets
`define FSAC_OFS_CTRL      12'h000
`define FSAC_OFS_STATUS    12'h004
`define FSAC_OFS_LOCK      12'h008

// ==================================================
// field positions
`define FSAC_CTRL_RRE      0
`define FSAC_CTRL_VEC_BOOT 1
`define FSAC_ST_BUSY       0
`define FSAC_ST_ACTIVE     1
`define FSAC_ST_HALT       2
`define FSAC_ST_BOOT_OFF   3
`define FSAC_LOCK_APP_LO   0
`define FSAC_LOCK_APP_HI   1
`define FSAC_LOCK_BOOT_LO  2
`define FSAC_LOCK_BOOT_HI  3

// ==================================================
// reset values
`define FSAC_LOCK_RESET    4'hF
`define FSAC_VEC_RESET     1'b0

// ==================================================
// timing
`define FSAC_CLK_PERIOD_NS 4
`define FSAC_OP_TIME_NS    4000
`define FSAC_OP_CYCLES     ((`FSAC_OP_TIME_NS + `FSAC_CLK_PERIOD_NS - 1) / `FSAC_CLK_PERIOD_NS)
`define FSAC_CNT_W         12

`endif

/* shared/fsac_pkg.sv */
package fsac_pkg;

	// ==================================================
	// types
	typedef enum logic [1:0] {
		FSAC_PAGE_ERASE = 2'h0,
		FSAC_PAGE_WRITE = 2'h1,
		FSAC_PAGE_LOAD  = 2'h2,
		FSAC_LOCK_SET   = 2'h3
	} fsac_store_kind_type;

	typedef enum logic [2:0] {
		FSAC_IDLE      = 3'h1,
		FSAC_RUN_CONC  = 3'h2,
		FSAC_RUN_HALT  = 3'h4
	} fsac_state_type;

endpackage

/* verilog/fsac_region_decode.sv */
`timescale 1ns/100ps
`include "fsac_defines.svh"

module fsac_region_decode import fsac_pkg::*; (
	input  wire logic [`FSAC_ADDR_W-1:0] addr,
	input  wire logic [1:0]              boot_size_fuses,
	input  wire logic                    boot_disable,
	output logic                         in_boot,
	output logic                         in_halting
);

	logic [`FSAC_ADDR_W-1:0] boot_words;
	logic [`FSAC_ADDR_W-1:0] boot_start;

	// ==================================================
	// partition and fixed region decode
	always_comb begin
		case (boot_size_fuses)
			2'b11:   boot_words = `FSAC_BOOT_WORDS_3;
			2'b10:   boot_words = `FSAC_BOOT_WORDS_2;
			2'b01:   boot_words = `FSAC_BOOT_WORDS_1;
			default: boot_words = `FSAC_BOOT_WORDS_0;
		endcase
		boot_start = 16'h0000 - boot_words;
		in_halting = (addr >= `FSAC_HALT_START);
		// boot partition never reaches below the halting region
		in_boot    = !boot_disable && (addr >= boot_start) && in_halting;
	end

endmodule // fsac_region_decode

/* verilog/fsac_self_program_ctrl.sv */
//Contract
//- store instruction from application partition is ignored
//- store from boot partition may target any page, boot included
//- boot/application boundary comes from boot size fuses
//- application protection from the application lock pair
//- boot protection from the separate boot lock pair
//- the two lock pairs are independent of each other
//- concurrent or halting behaviour chosen from target address region
//- concurrent-region operation keeps cpu running from halting region
//- halting-region operation halts cpu for whole operation
//- concurrent region never delivers code while held by programming
//- boot partition always lies inside halting region
//- busy flag reads one while concurrent region reads are blocked
//- with boot disabled whole flash is application space
//- busy set on concurrent erase/write; cleared by read enable or load
//- lock pair: 11 free, 10 no write, 00 no write/read, 01 no read
//- locks only get programmed; only chip erase unprograms them (presetn here also reloads all ones)
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "fsac_defines.svh"

module fsac_self_program_ctrl import fsac_pkg::*; (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [1:0]                boot_size_fuses,
	input  wire logic                      boot_disable,
	input  wire logic [`FSAC_ADDR_W-1:0]   fetch_addr,
	input  wire logic                      store_req,
	input  wire fsac_store_kind_type       store_kind,
	input  wire logic [`FSAC_ADDR_W-1:0]   store_addr,
	input  wire logic [3:0]                store_lock_data,
	input  wire logic [`FSAC_ADDR_W-1:0]   tread_addr,
	input  wire logic                      ext_lock_wr,
	input  wire logic [3:0]                ext_lock_data,
	input  wire logic                      chip_erase,
	output logic                           store_accept,
	output logic                           store_refuse,
	output logic                           flash_op_start,
	output logic                           flash_op_erase,
	output logic [`FSAC_ADDR_W-1:0]        flash_op_addr,
	output logic                           cpu_halt,
	output logic                           fetch_block,
	output logic                           tread_block,
	output logic                           irq_suppress,
	output logic                           region_busy_flag,
	output logic [3:0]                     lock_bits
);

	// ==================================================
	// lock pair decode, 0 = programmed
	function automatic logic lock_wr_blk(input logic [1:0] pair);
		lock_wr_blk = !pair[0];
	endfunction

	function automatic logic lock_rd_blk(input logic [1:0] pair);
		lock_rd_blk = !pair[1];
	endfunction

	// ==================================================
	// region decoders
	logic pc_boot;
	logic pc_halting;
	logic tgt_boot;
	logic tgt_halting;
	logic rd_boot;
	logic rd_halting;

	fsac_region_decode u_pc_dec (
		.addr            (fetch_addr),
		.boot_size_fuses (boot_size_fuses),
		.boot_disable    (boot_disable),
		.in_boot         (pc_boot),
		.in_halting      (pc_halting)
	);

	fsac_region_decode u_tgt_dec (
		.addr            (store_addr),
		.boot_size_fuses (boot_size_fuses),
		.boot_disable    (boot_disable),
		.in_boot         (tgt_boot),
		.in_halting      (tgt_halting)
	);

	fsac_region_decode u_rd_dec (
		.addr            (tread_addr),
		.boot_size_fuses (boot_size_fuses),
		.boot_disable    (boot_disable),
		.in_boot         (rd_boot),
		.in_halting      (rd_halting)
	);

	// ==================================================
	// state
	fsac_state_type            state_q, state_d;
	logic [`FSAC_CNT_W-1:0]    cnt_q, cnt_d;
	logic                      busy_q, busy_d;
	logic [3:0]                lock_q, lock_d;
	logic                      vec_boot_q, vec_boot_d;
	logic [31:0]               prdata_q, prdata_d;
	logic                      start_q, start_d;
	logic                      erase_q, erase_d;
	logic [`FSAC_ADDR_W-1:0]   op_addr_q, op_addr_d;

	logic apb_setup;
	logic apb_wr;
	logic map_hit;
	logic is_prog;
	logic tgt_wr_blk;
	logic app_rd_blk;
	logic boot_rd_blk;
	logic rre_clear;
	logic load_start;
	logic lock_start;

	assign apb_setup  = psel && !penable;
	assign apb_wr     = psel && penable && pwrite;
	assign map_hit    = (paddr == `FSAC_OFS_CTRL) || (paddr == `FSAC_OFS_STATUS) || (paddr == `FSAC_OFS_LOCK);
	assign pready     = psel && penable;
	assign pslverr    = psel && penable && !map_hit;
	assign prdata     = prdata_q;

	assign app_rd_blk  = lock_rd_blk(lock_q[`FSAC_LOCK_APP_HI:`FSAC_LOCK_APP_LO]);
	assign boot_rd_blk = lock_rd_blk(lock_q[`FSAC_LOCK_BOOT_HI:`FSAC_LOCK_BOOT_LO]);
	// each partition only looks at its own pair
	assign tgt_wr_blk  = tgt_boot ? lock_wr_blk(lock_q[`FSAC_LOCK_BOOT_HI:`FSAC_LOCK_BOOT_LO])
	                              : lock_wr_blk(lock_q[`FSAC_LOCK_APP_HI:`FSAC_LOCK_APP_LO]);

	// ==================================================
	// store instruction acceptance
	always_comb begin
		is_prog    = (store_kind == FSAC_PAGE_ERASE) || (store_kind == FSAC_PAGE_WRITE);
		// only code in boot partition may store; erase/write only to a target page whose lock pair allows writing
		store_accept = store_req && pc_boot && (state_q == FSAC_IDLE) && !(is_prog && tgt_wr_blk);
		store_refuse = store_req && !store_accept;
		load_start   = store_accept && (store_kind == FSAC_PAGE_LOAD);
		lock_start   = store_accept && (store_kind == FSAC_LOCK_SET);
		rre_clear    = apb_wr && (paddr == `FSAC_OFS_CTRL) && pwdata[`FSAC_CTRL_RRE] && (state_q == FSAC_IDLE);
	end

	// ==================================================
	// sequencer next state
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		start_d   = 1'b0;
		erase_d   = erase_q;
		op_addr_d = op_addr_q;
		case (state_q)
			FSAC_IDLE: begin
				if (store_accept && is_prog) begin
					start_d   = 1'b1;
					erase_d   = (store_kind == FSAC_PAGE_ERASE);
					op_addr_d = store_addr;
					cnt_d     = `FSAC_CNT_W'(`FSAC_OP_CYCLES - 1);
					state_d   = tgt_halting ? FSAC_RUN_HALT : FSAC_RUN_CONC;
				end
			end
			FSAC_RUN_CONC, FSAC_RUN_HALT: begin
				if (cnt_q == '0) begin
					state_d = FSAC_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = FSAC_IDLE;
			end
		endcase
		// set wins over clear; load start also clears
		busy_d = (busy_q && !(rre_clear || load_start)) || (store_accept && is_prog && !tgt_halting);
	end

	// ==================================================
	// lock bits: programming only ANDs, erase restores all ones
	always_comb begin
		lock_d = lock_q;
		if (lock_start) begin
			lock_d = lock_d & store_lock_data;
		end
		if (ext_lock_wr) begin
			lock_d = lock_d & ext_lock_data;
		end
		if (apb_wr && (paddr == `FSAC_OFS_LOCK)) begin
			lock_d = lock_d & pwdata[3:0];
		end
		if (chip_erase) begin
			lock_d = `FSAC_LOCK_RESET;
		end
		vec_boot_d = vec_boot_q;
		if (apb_wr && (paddr == `FSAC_OFS_CTRL)) begin
			vec_boot_d = pwdata[`FSAC_CTRL_VEC_BOOT];
		end
	end

	// ==================================================
	// apb read data captured in setup, shown in access phase
	always_comb begin
		prdata_d = prdata_q;
		if (apb_setup && !pwrite) begin
			prdata_d = 32'h0000_0000;
			case (paddr)
				`FSAC_OFS_CTRL: begin
					prdata_d[`FSAC_CTRL_VEC_BOOT] = vec_boot_q;
				end
				`FSAC_OFS_STATUS: begin
					prdata_d[`FSAC_ST_BUSY]     = busy_q;
					prdata_d[`FSAC_ST_ACTIVE]   = (state_q != FSAC_IDLE);
					prdata_d[`FSAC_ST_HALT]     = (state_q == FSAC_RUN_HALT);
					prdata_d[`FSAC_ST_BOOT_OFF] = boot_disable;
				end
				`FSAC_OFS_LOCK: begin
					prdata_d[3:0] = lock_q;
				end
				default: begin
					prdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= FSAC_IDLE;
			cnt_q      <= '0;
			busy_q     <= 1'b0;
			lock_q     <= `FSAC_LOCK_RESET;
			vec_boot_q <= `FSAC_VEC_RESET;
			prdata_q   <= 32'h0000_0000;
			start_q    <= 1'b0;
			erase_q    <= 1'b0;
			op_addr_q  <= '0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			busy_q     <= busy_d;
			lock_q     <= lock_d;
			vec_boot_q <= vec_boot_d;
			prdata_q   <= prdata_d;
			start_q    <= start_d;
			erase_q    <= erase_d;
			op_addr_q  <= op_addr_d;
		end
	end

	// ==================================================
	// cpu side gating
	assign region_busy_flag = busy_q;
	assign lock_bits        = lock_q;
	assign flash_op_start   = start_q;
	assign flash_op_erase   = erase_q;
	assign flash_op_addr    = op_addr_q;
	assign cpu_halt         = (state_q == FSAC_RUN_HALT);
	// concurrent region stays dark until software clears busy
	assign fetch_block  = cpu_halt || (busy_q && !pc_halting);
	assign tread_block  = cpu_halt || (busy_q && !rd_halting) ||
	                      (pc_boot && !rd_boot && app_rd_blk) || (!pc_boot && rd_boot && boot_rd_blk);
	// vectors in the other partition would leak through a read lock
	assign irq_suppress = (vec_boot_q && !pc_boot && app_rd_blk) || (!vec_boot_q && pc_boot && boot_rd_blk);

	// ==================================================
	// checks
	logic [`FSAC_CNT_W-1:0] halt_run_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_run_q <= '0;
		end else begin
			halt_run_q <= cpu_halt ? halt_run_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_app_ignored;
		store_req && !pc_boot |-> store_refuse && !store_accept;
	endproperty
	a_app_ignored: assert property (p_app_ignored) else $error("store from application accepted");

	property p_busy_set;
		store_accept && is_prog && !tgt_halting |=> region_busy_flag && !cpu_halt;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set on concurrent op");

	property p_halt_start;
		store_accept && is_prog && tgt_halting |=> cpu_halt && flash_op_start;
	endproperty
	a_halt_start: assert property (p_halt_start) else $error("halting op did not halt cpu");

	property p_halt_len;
		$fell(cpu_halt) |-> halt_run_q == `FSAC_CNT_W'(`FSAC_OP_CYCLES);
	endproperty
	a_halt_len: assert property (p_halt_len) else $error("halt length wrong");

	property p_no_conc_fetch;
		region_busy_flag && !pc_halting |-> fetch_block;
	endproperty
	a_no_conc_fetch: assert property (p_no_conc_fetch) else $error("concurrent region fetch while busy");

	property p_boot_in_halting;
		pc_boot |-> pc_halting;
	endproperty
	a_boot_in_halting: assert property (p_boot_in_halting) else $error("boot outside halting region");

	property p_status_busy;
		apb_setup && !pwrite && paddr == `FSAC_OFS_STATUS |=> prdata[0] == $past(region_busy_flag);
	endproperty
	a_status_busy: assert property (p_status_busy) else $error("status busy mismatch");

	property p_lock_monotone;
		!chip_erase |=> (lock_bits & ~$past(lock_bits)) == 4'h0;
	endproperty
	a_lock_monotone: assert property (p_lock_monotone) else $error("lock unprogrammed without erase");

	property p_wr_locked;
		store_req && is_prog && tgt_wr_blk |-> !store_accept ##1 !flash_op_start;
	endproperty
	a_wr_locked: assert property (p_wr_locked) else $error("write to locked partition started");

	property p_load_clears;
		load_start && !(store_accept && is_prog) |=> !region_busy_flag;
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("page load did not clear busy");

endmodule // fsac_self_program_ctrl

/* sim/fsac_cpu_model.sv */
`timescale 1ns/100ps
`include "fsac_defines.svh"

module fsac_cpu_model import fsac_pkg::*; (
	input  wire logic                    pclk,
	input  wire logic                    store_accept,
	input  wire logic                    store_refuse,
	output logic [`FSAC_ADDR_W-1:0]      fetch_addr,
	output logic                         store_req,
	output fsac_store_kind_type          store_kind,
	output logic [`FSAC_ADDR_W-1:0]      store_addr,
	output logic [3:0]                   store_lock_data,
	output logic [`FSAC_ADDR_W-1:0]      tread_addr
);
	// ==================================================
	// idle core: executes from the boot partition, no interrupts taken
	initial begin
		fetch_addr      = 16'hFE00;
		store_req       = 1'b0;
		store_kind      = FSAC_PAGE_LOAD;
		store_addr      = 16'h0000;
		store_lock_data = 4'hF;
		tread_addr      = 16'h0000;
	end

	// ==================================================
	// one store instruction; outcome {accept,refuse} taken at the closing edge
	task automatic exec(input logic [15:0] pc, input fsac_store_kind_type k, input logic [15:0] z,
			output logic [1:0] res);
		@(posedge pclk);
		fetch_addr <= pc;
		store_req  <= 1'b1;
		store_kind <= k;
		store_addr <= z;
		tread_addr <= z;
		// lock set takes its new lock value from the low bits of the operand
		store_lock_data <= z[3:0];
		@(posedge pclk);
		res = {store_accept, store_refuse};
		store_req <= 1'b0;
	endtask
endmodule // fsac_cpu_model

/* sim/tb.sv */
`timescale 1ns/100ps
`include "fsac_defines.svh"

module tb import fsac_pkg::*; ;
	logic                pclk = 1'b0;
	logic                presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic [1:0]          fuses, res;
	logic                boot_disable, ext_lock_wr, chip_erase, store_req, store_accept, store_refuse;
	logic                flash_op_start, flash_op_erase, cpu_halt, fetch_block, tread_block;
	logic                irq_suppress, region_busy_flag;
	logic [3:0]          ext_lock_data, lock_bits, store_lock_data;
	logic [15:0]         fetch_addr, store_addr, tread_addr, flash_op_addr, bs;
	fsac_store_kind_type store_kind;
	int                  fail_count = 0;
	int                  check_count = 0;
	int                  n;

	always #2 pclk = ~pclk;

	fsac_self_program_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .boot_size_fuses(fuses), .boot_disable, .fetch_addr, .store_req, .store_kind,
		.store_addr, .store_lock_data, .tread_addr, .ext_lock_wr, .ext_lock_data, .chip_erase,
		.store_accept, .store_refuse, .flash_op_start, .flash_op_erase, .flash_op_addr, .cpu_halt,
		.fetch_block, .tread_block, .irq_suppress, .region_busy_flag, .lock_bits);

	fsac_cpu_model cpu (.pclk, .store_accept, .store_refuse, .fetch_addr, .store_req, .store_kind,
		.store_addr, .store_lock_data, .tread_addr);

	// ==================================================
	// checking and closing
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==================================================
	// apb master; leaves read data in rd and the error flag in err
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			fail_count++;
			conclude();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// poll status until the flash operation has finished
	task automatic wait_idle();
		int i;
		for (i = 0; i < 400; i++) begin
			apb(1'b0, 12'h004, 32'h0);
			if (rd[1] === 1'b0) break;
		end
		if (i == 400) begin
			fail_count++;
			conclude();
		end
	endtask

	task automatic st(input logic [15:0] pc, input fsac_store_kind_type k, input logic [15:0] z,
			input logic [1:0] e);
		cpu.exec(pc, k, z, res);
		chk("store outcome", 32'(res), 32'(e));
	endtask

	// ==================================================
	// main sequence
	initial begin
		presetn       = 1'b0;
		psel          = 1'b0;
		penable       = 1'b0;
		pwrite        = 1'b0;
		paddr         = 12'h000;
		pwdata        = 32'h0;
		fuses         = 2'h3;
		boot_disable  = 1'b0;
		ext_lock_wr   = 1'b0;
		ext_lock_data = 4'hF;
		chip_erase    = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h008, 32'h0);
		chk("lock reset", rd, 32'hF);
		apb(1'b0, 12'h004, 32'h0);
		chk("status reset", rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped", {rd[30:0], err}, 32'h1);
		// first boot word accepted, the word below it is application code
		for (int f = 0; f < 4; f++) begin
			fuses <= f[1:0];
			bs = 16'h0000 - (16'h0200 << (3 - f));
			st(bs, FSAC_PAGE_LOAD, 16'h0000, 2'b10);
			st(bs - 16'h1, FSAC_PAGE_LOAD, 16'h0000, 2'b01);
		end
		st(16'hFE00, FSAC_PAGE_WRITE, 16'h0100, 2'b10);
		#1;
		chk("conc op", 32'({flash_op_start, flash_op_erase, cpu_halt, fetch_block, tread_block}), 32'h11);
		chk("conc addr", 32'({region_busy_flag, flash_op_addr}), 32'h10100);
		st(16'hFE00, FSAC_PAGE_LOAD, 16'h0000, 2'b01);
		wait_idle();
		chk("busy after op", rd, 32'h1);
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("busy cleared", rd, 32'h0);
		st(16'hFE00, FSAC_PAGE_ERASE, 16'h0200, 2'b10);
		wait_idle();
		st(16'hFE00, FSAC_PAGE_LOAD, 16'h0000, 2'b10);
		#1;
		chk("load clears busy", 32'(region_busy_flag), 32'h0);
		// boot partition erases its own page: core halted throughout
		st(16'hFE00, FSAC_PAGE_ERASE, 16'hFF00, 2'b10);
		#1;
		chk("halt op", 32'({flash_op_erase, cpu_halt, fetch_block, tread_block}), 32'hF);
		n = 0;
		repeat (1010) begin
			@(posedge pclk);
			if (cpu_halt === 1'b1) n++;
		end
		chk("halt cycles", 32'(n), 32'(`FSAC_OP_CYCLES));
		apb(1'b1, 12'h008, 32'hE);
		#1;
		chk("app lock", 32'(lock_bits), 32'hE);
		st(16'hFE00, FSAC_PAGE_ERASE, 16'h0100, 2'b01);
		st(16'hFE00, FSAC_PAGE_WRITE, 16'hFE00, 2'b10);
		wait_idle();
		@(posedge pclk);
		ext_lock_wr   <= 1'b1;
		ext_lock_data <= 4'hB;
		@(posedge pclk);
		ext_lock_wr <= 1'b0;
		#1;
		chk("ext lock", 32'(lock_bits), 32'hA);
		st(16'hFE00, FSAC_PAGE_ERASE, 16'hFF00, 2'b01);
		apb(1'b1, 12'h008, 32'hF);
		apb(1'b1, 12'h008, 32'h3);
		#1;
		chk("lock only lowers", 32'(lock_bits), 32'h2);
		st(16'h0000, FSAC_PAGE_LOAD, 16'hFF00, 2'b01);
		#1;
		chk("cross read lock", 32'(tread_block), 32'h1);
		@(posedge pclk);
		chip_erase <= 1'b1;
		@(posedge pclk);
		chip_erase <= 1'b0;
		#1;
		chk("chip erase", 32'({lock_bits, tread_block}), 32'h1E);
		// application pair read-locked only; vectors still in application space
		st(16'hFE00, FSAC_LOCK_SET, 16'h000D, 2'b10);
		#1;
		chk("lock set", 32'({lock_bits, irq_suppress}), 32'h1A);
		apb(1'b1, 12'h000, 32'h2);
		st(16'h0100, FSAC_PAGE_LOAD, 16'h0000, 2'b01);
		#1;
		chk("irq suppressed", 32'(irq_suppress), 32'h1);
		@(posedge pclk);
		boot_disable <= 1'b1;
		st(16'hFE00, FSAC_PAGE_LOAD, 16'h0000, 2'b01);
		apb(1'b0, 12'h004, 32'h0);
		chk("boot off", rd, 32'h8);
		conclude();
	end
endmodule // tb
